// ===== hw/dml_top.sv
// decode array and general logic array with sixteen output cells
//
// Behaviour
// - arrays see address, strobes, ports, pages, feedback, busy
// - fast bit clear: idle arrays enter standby
// - five gating bits block processor strobes
// - four primary selects, three terms each
// - two secondary selects, three terms each
// - sram select from two terms
// - one control register space select
// - two peripheral selects
// - two external chip selects, no cell used
// - 69 inputs, 16 cells, 137 terms
// - processor loads cells, reads inputs and cells
// - ab cells to ports a/b, bc to b/c
// - xor stage sets cell polarity
// - mux picks ff or comb, feeds back
// - ff acts as d, t, jk or sr
// - cell clock from term or external pin
// - active high preset and two-term clear
// - native and borrowed term limits per group
// - port c test pins never carry cells
// - logic image live from power-up
// - processor load beats preset, clear, clock
// - mask bit one blocks processor load
// - load on strobe end or during strobe
`timescale 1ns/1ps
module dml_top #(
  parameter logic [dml_pkg::CFG_BYTES*8-1:0] LOGIC_IMAGE = '0  // stored logic image
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // processor core signals, same clock
  input wire logic [15:0] cpu_addr_i,
  input wire logic program_fetch_strobe_i,
  input wire logic data_read_strobe_i,
  input wire logic data_write_strobe_i,
  input wire logic addr_latch_strobe_i,
  input wire logic cpu_reset_i,
  input wire logic power_down_input_i,
  input wire logic [7:0] page_bits_i,
  input wire logic ready_busy_i,
  // pins, asynchronous
  input wire logic [7:0] port_a_pins_i,
  input wire logic [7:0] port_b_pins_i,
  input wire logic [3:0] port_c_pins_i,
  input wire logic external_cell_clock_i,
  input wire logic port_d2_i,
  // decode selects
  output dml_pkg::dml_dec_t dec_sel_o,
  // chip selects, cell outputs towards ports, standby flag
  output logic [1:0] external_chip_selects_o,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_en_o,
  output logic [7:0] port_b_o,
  output logic [7:0] port_b_en_o,
  output logic [7:0] port_c_o,
  output logic [7:0] port_c_en_o,
  output logic standby_o
);

  dml_pkg::dml_state_t s_q;  // registered state
  dml_pkg::dml_state_t s_d;  // next state
  logic [dml_pkg::N_IN-1:0] x;  // array inputs after gating
  logic [dml_pkg::N_TERMS-1:0] pt;  // product terms
  logic [15:0] borrow;  // borrowed sum per cell
  logic [15:0] comb_out;  // polarity-corrected sums
  logic [15:0] ld_en;  // processor load per cell
  logic [7:0] ld_data;  // data being loaded
  logic ext_rise;  // external clock rising edge

  // one product term: inputs against true and inverted masks
  function automatic logic term_eval(input logic [dml_pkg::TERM_BYTES*8-1:0] b,
                                     input logic [dml_pkg::N_IN-1:0] v);
    logic [dml_pkg::N_IN-1:0] hit;
    hit = (v | ~b[dml_pkg::N_IN-1:0]) & (~v | ~b[2*dml_pkg::N_IN-1:dml_pkg::N_IN]);
    return b[dml_pkg::TERM_EN_BIT] & (&hit);
  endfunction

  // borrow ceiling of a cell
  function automatic int borrow_max(input int c);
    if (c < 8) begin
      return dml_pkg::AB_BORROW;
    end else if (c < 12) begin
      return dml_pkg::BC_LO_BORROW;
    end
    return dml_pkg::BC_HI_BORROW;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic q;
    logic s;
    logic k;
    logic nq;
    logic ev;
    logic [7:0] cb;
    logic [7:0] own;
    logic [2:0] used [16];
    int nb;
    int nat;
    int oc;
    q = 1'b0;
    s = 1'b0;
    k = 1'b0;
    nq = 1'b0;
    ev = 1'b0;
    cb = 8'h00;
    own = 8'h00;
    nb = 0;
    nat = 0;
    oc = 0;
    for (int c = 0; c < 16; c++) begin
      used[c] = 3'h0;
    end
    s_d = s_q;

    // pins through two flops; first stage read only by second
    s_d.in_s1 = {port_d2_i, external_cell_clock_i, port_c_pins_i, port_b_pins_i,
                 port_a_pins_i};
    s_d.in_s2 = s_q.in_s1;
    s_d.clk_ext_prev = s_q.in_s2[20];
    ext_rise = s_q.in_s2[20] & ~s_q.clk_ext_prev;

    // array inputs; feedback is the registered cell outputs so no loop forms
    x = {ready_busy_i, s_q.cell_out, page_bits_i, s_q.in_s2[21:20], s_q.in_s2[19:0],
         power_down_input_i & ~s_q.pmr2[dml_pkg::GATE_PDN],
         cpu_reset_i,
         program_fetch_strobe_i & ~s_q.pmr2[dml_pkg::GATE_PROGRAM_FETCH_STROBE],
         data_write_strobe_i & ~s_q.pmr2[dml_pkg::GATE_WR],
         data_read_strobe_i & ~s_q.pmr2[dml_pkg::GATE_RD],
         addr_latch_strobe_i & ~s_q.pmr2[dml_pkg::GATE_ALE],
         cpu_addr_i};

    // all 160 terms, 137 general then 23 decode
    for (int t = 0; t < dml_pkg::N_TERMS; t++) begin
      pt[t] = term_eval(s_q.cfg[t*dml_pkg::TERM_BYTES +: dml_pkg::TERM_BYTES], x);
    end

    // pool lending: one owner per term, first come within the ceiling
    borrow = 16'h0000;
    for (int p = 0; p < dml_pkg::N_POOL; p++) begin
      own = s_q.cfg[dml_pkg::POOL_OWN_BASE + p];
      oc = int'(own[3:0]);
      if (own[dml_pkg::OWN_VALID] && int'(used[oc]) < borrow_max(oc)) begin
        borrow[oc] = borrow[oc] | pt[dml_pkg::PT_POOL + p];
        used[oc] = used[oc] + 3'h1;
      end
    end

    // processor loads: during the strobe or in the cycle after it
    if (s_q.ctrl[dml_pkg::CTRL_EDGE_LOAD]) begin
      ld_data = s_q.pend_data;
      ld_en = {{8{s_q.pend_bc}} & ~s_q.mask_bc, {8{s_q.pend_ab}} & ~s_q.mask_ab};
    end else begin
      ld_data = reg_wdata_i;
      ld_en = {{8{reg_wr_i && reg_addr_i == dml_pkg::REG_CELLS_BC}} & ~s_q.mask_bc,
               {8{reg_wr_i && reg_addr_i == dml_pkg::REG_CELLS_AB}} & ~s_q.mask_ab};
    end
    s_d.pend_ab = reg_wr_i && reg_addr_i == dml_pkg::REG_CELLS_AB;
    s_d.pend_bc = reg_wr_i && reg_addr_i == dml_pkg::REG_CELLS_BC;
    s_d.pend_data = reg_wdata_i;

    // output cells
    for (int c = 0; c < 16; c++) begin
      cb = s_q.cfg[dml_pkg::CELL_CFG_BASE + c];
      nat = (c < 8) ? dml_pkg::AB_NATIVE : dml_pkg::BC_NATIVE;
      nb = (c < 8) ? dml_pkg::AB_NATIVE * c : dml_pkg::PT_BC_NATIVE + dml_pkg::BC_NATIVE * (c - 8);
      q = s_q.cell_ff[c];
      k = pt[nb];
      s = borrow[c];
      // jk and sr take their k or r from the first native term alone
      for (int n = 0; n < 4; n++) begin
        if (n < nat && !(cb[dml_pkg::CC_TYPE+1] && n == 0)) begin
          s = s | pt[nb + n];
        end
      end
      s = s ^ cb[dml_pkg::CC_INV];
      comb_out[c] = s;
      ev = cb[dml_pkg::CC_EXT_CLK] ? ext_rise
         : (pt[dml_pkg::PT_CTL_BASE + 4*c] & ~s_q.clk_prev[c]);
      s_d.clk_prev[c] = pt[dml_pkg::PT_CTL_BASE + 4*c];
      case (cb[dml_pkg::CC_TYPE +: 2])
        2'h0: nq = s;  // d
        2'h1: nq = q ^ s;  // t
        2'h2: nq = (s & ~q) | (~k & q);  // jk
        default: nq = s ? 1'b1 : (k ? 1'b0 : q);  // sr
      endcase
      if (!ev) begin
        nq = q;
      end
      // clear wins over preset; both plain levels
      if (pt[dml_pkg::PT_CTL_BASE + 4*c + 2] | pt[dml_pkg::PT_CTL_BASE + 4*c + 3]) begin
        nq = 1'b0;
      end else if (pt[dml_pkg::PT_CTL_BASE + 4*c + 1]) begin
        nq = 1'b1;
      end
      if (ld_en[c]) begin
        nq = ld_data[c % 8];
      end
      s_d.cell_ff[c] = nq;
      s_d.cell_out[c] = cb[dml_pkg::CC_USE_FF] ? nq : comb_out[c];
    end

    // pin routing; ab has priority over bc on a shared port b pin
    s_d.pa_en = 8'h00;
    s_d.pb_en = 8'h00;
    s_d.pc_en = 8'h00;
    s_d.pa = 8'h00;
    s_d.pb = 8'h00;
    s_d.pc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      cb = s_q.cfg[dml_pkg::CELL_CFG_BASE + i];
      if (cb[dml_pkg::CC_ALT_PORT]) begin
        s_d.pb[i] = s_d.cell_out[i];
        s_d.pb_en[i] = 1'b1;
      end else begin
        s_d.pa[i] = s_d.cell_out[i];
        s_d.pa_en[i] = 1'b1;
      end
      cb = s_q.cfg[dml_pkg::CELL_CFG_BASE + 8 + i];
      // test pins 0,1,5,6 of port c stay with the test port
      if (cb[dml_pkg::CC_ALT_PORT] && i != 0 && i != 1 && i != 5 && i != 6) begin
        s_d.pc[i] = s_d.cell_out[8 + i];
        s_d.pc_en[i] = 1'b1;
      end else if (!s_d.pb_en[i]) begin
        s_d.pb[i] = s_d.cell_out[8 + i];
        s_d.pb_en[i] = 1'b1;
      end
    end

    // external chip selects straight from their own terms
    s_d.ecs = pt[dml_pkg::PT_ECS +: 2];

    // decode array sums
    for (int i = 0; i < 4; i++) begin
      s_d.dec.primary_sector_selects[i] = |pt[dml_pkg::PT_PRIM + 3*i +: 3];
    end
    for (int i = 0; i < 2; i++) begin
      s_d.dec.secondary_sector_selects[i] = |pt[dml_pkg::PT_SEC + 3*i +: 3];
    end
    s_d.dec.sram_select = |pt[dml_pkg::PT_SRAM +: 2];
    s_d.dec.control_register_space = pt[dml_pkg::PT_CREG];
    s_d.dec.peripheral_selects = pt[dml_pkg::PT_PERI +: 2];

    // standby after the inputs stand still; power only, outputs unchanged
    s_d.in_prev = x;
    if (s_q.pmr0[dml_pkg::PMR0_FAST] || x != s_q.in_prev) begin
      s_d.idle_cnt = 5'h00;
      s_d.standby = 1'b0;
    end else if (int'(s_q.idle_cnt) < dml_pkg::STBY_CYC) begin
      s_d.idle_cnt = s_q.idle_cnt + 5'h01;
      s_d.standby = 1'b0;
    end else begin
      s_d.standby = 1'b1;
    end

    // register writes
    if (reg_wr_i) begin
      if (reg_addr_i == dml_pkg::REG_MASK_AB) begin
        s_d.mask_ab = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_MASK_BC) begin
        s_d.mask_bc = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_PMR0) begin
        s_d.pmr0 = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_PMR2) begin
        s_d.pmr2 = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_CTRL) begin
        s_d.ctrl = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_PROG_LO) begin
        s_d.prog_addr[7:0] = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_PROG_HI) begin
        s_d.prog_addr[15:8] = reg_wdata_i;
      end else if (reg_addr_i == dml_pkg::REG_PROG_DATA) begin
        // out-of-range bytes are dropped but the pointer still steps
        if (int'(s_q.prog_addr) < dml_pkg::CFG_BYTES) begin
          s_d.cfg[s_q.prog_addr] = reg_wdata_i;
        end
        s_d.prog_addr = s_q.prog_addr + 16'h0001;
      end
    end

    // register reads, data valid only in the following cycle
    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == dml_pkg::REG_CELLS_AB) begin
        s_d.rdata = s_q.cell_ff[7:0];
      end else if (reg_addr_i == dml_pkg::REG_CELLS_BC) begin
        s_d.rdata = s_q.cell_ff[15:8];
      end else if (reg_addr_i == dml_pkg::REG_IN_A) begin
        s_d.rdata = s_q.in_s2[7:0];
      end else if (reg_addr_i == dml_pkg::REG_IN_B) begin
        s_d.rdata = s_q.in_s2[15:8];
      end else if (reg_addr_i == dml_pkg::REG_IN_C) begin
        s_d.rdata = {s_q.in_s2[19], 2'h0, s_q.in_s2[18:16], 2'h0};
      end else if (reg_addr_i == dml_pkg::REG_MASK_AB) begin
        s_d.rdata = s_q.mask_ab;
      end else if (reg_addr_i == dml_pkg::REG_MASK_BC) begin
        s_d.rdata = s_q.mask_bc;
      end else if (reg_addr_i == dml_pkg::REG_PMR0) begin
        s_d.rdata = s_q.pmr0;
      end else if (reg_addr_i == dml_pkg::REG_PMR2) begin
        s_d.rdata = s_q.pmr2;
      end else if (reg_addr_i == dml_pkg::REG_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (reg_addr_i == dml_pkg::REG_STATUS) begin
        s_d.rdata = {7'h00, s_q.standby};
      end else if (reg_addr_i == dml_pkg::REG_PROG_LO) begin
        s_d.rdata = s_q.prog_addr[7:0];
      end else if (reg_addr_i == dml_pkg::REG_PROG_HI) begin
        s_d.rdata = s_q.prog_addr[15:8];
      end else if (reg_addr_i == dml_pkg::REG_PROG_DATA) begin
        if (int'(s_q.prog_addr) < dml_pkg::CFG_BYTES) begin
          s_d.rdata = s_q.cfg[s_q.prog_addr];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset reloads the stored image, so logic runs unaided
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.cfg <= LOGIC_IMAGE;
      s_q.pmr0 <= dml_pkg::PMR0_RST;
      s_q.pmr2 <= dml_pkg::PMR2_RST;
      s_q.mask_ab <= dml_pkg::MASK_RST;
      s_q.mask_bc <= dml_pkg::MASK_RST;
      s_q.ctrl <= dml_pkg::CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = s_q.rdata;
  assign dec_sel_o = s_q.dec;
  assign external_chip_selects_o = s_q.ecs;
  assign port_a_o = s_q.pa;
  assign port_a_en_o = s_q.pa_en;
  assign port_b_o = s_q.pb;
  assign port_b_en_o = s_q.pb_en;
  assign port_c_o = s_q.pc;
  assign port_c_en_o = s_q.pc_en;
  assign standby_o = s_q.standby;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_main @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  fast_no_standby_a: assert property (s_q.pmr0[dml_pkg::PMR0_FAST] |=> !standby_o)
    else $error("standby while fast bit set");
  strobe_gate_a: assert property (s_q.pmr2[2] |-> !x[18])
    else $error("gated write strobe reached array");
  sram_sum_a: assert property ((pt[155] || pt[156]) |=> dec_sel_o.sram_select)
    else $error("sram select missed its term");
  chip_sel_a: assert property (pt[120] |=> external_chip_selects_o[0])
    else $error("chip select missed its term");
  level_load_a: assert property (reg_wr_i && reg_addr_i == 8'h10 && !s_q.ctrl[0]
      && !s_q.mask_ab[0] |=> s_q.cell_ff[0] == $past(reg_wdata_i[0]))
    else $error("level load not taken");
  edge_load_a: assert property (reg_wr_i && reg_addr_i == 8'h11 && s_q.ctrl[0]
      ##1 !s_q.mask_bc[3] |=> s_q.cell_ff[11] == $past(reg_wdata_i[3], 2))
    else $error("edge load not taken");
  mask_block_a: assert property (s_q.mask_ab[2] && !s_q.ctrl[0] && !pt[64] && !pt[65]
      && !pt[66] && !pt[67] && !ext_rise |=> s_q.cell_ff[2] == $past(s_q.cell_ff[2]))
    else $error("masked cell changed");
  test_pins_a: assert property (port_c_en_o[0] == 1'b0 && port_c_en_o[1] == 1'b0
      && port_c_en_o[5] == 1'b0 && port_c_en_o[6] == 1'b0)
    else $error("test pin drives cell");
  read_back_a: assert property (reg_rd_i && reg_addr_i == 8'h10
      |=> reg_rdata_o == $past(s_q.cell_ff[7:0]))
    else $error("cell read back wrong");

endmodule

// ===== inc/dml_pkg.sv
// shared constants and carrier types of the decode and macrocell logic block
package dml_pkg;

  // array shape
  localparam int N_IN = 69;           // array input count
  localparam int N_TERMS = 160;       // 137 general terms then 23 decode terms
  localparam int TERM_BYTES = 18;     // per term: true mask, inverted mask, enable
  localparam int TERM_EN_BIT = 138;   // term enable bit inside its bytes
  localparam int N_CELLS = 16;        // ab cells 0..7, bc cells 8..15
  localparam int N_POOL = 15;         // lendable terms
  localparam int CELL_CFG_BASE = N_TERMS * TERM_BYTES;
  localparam int POOL_OWN_BASE = CELL_CFG_BASE + N_CELLS;
  localparam int CFG_BYTES = POOL_OWN_BASE + N_POOL;

  // general array term map
  localparam int PT_BC_NATIVE = 24;   // first native term of bc cell 0
  localparam int PT_CTL_BASE = 56;    // clock, preset, clear0, clear1 per cell
  localparam int PT_ECS = 120;        // two external chip select terms
  localparam int PT_POOL = 122;       // lendable pool
  // decode array term map
  localparam int PT_PRIM = 137;       // 4 selects x 3 terms
  localparam int PT_SEC = 149;        // 2 selects x 3 terms
  localparam int PT_SRAM = 155;       // 2 terms
  localparam int PT_CREG = 157;       // 1 term
  localparam int PT_PERI = 158;       // 2 terms, one each

  // native and borrow limits
  localparam int AB_NATIVE = 3;
  localparam int BC_NATIVE = 4;
  localparam int AB_BORROW = 6;
  localparam int BC_LO_BORROW = 5;
  localparam int BC_HI_BORROW = 6;

  // cell configuration byte fields
  localparam int CC_INV = 0;
  localparam int CC_USE_FF = 1;
  localparam int CC_TYPE = 2;         // two bits
  localparam int CC_EXT_CLK = 4;
  localparam int CC_ALT_PORT = 5;
  localparam int OWN_VALID = 7;

  // register offsets
  localparam logic [7:0] REG_CELLS_AB = 8'h10;
  localparam logic [7:0] REG_CELLS_BC = 8'h11;
  localparam logic [7:0] REG_IN_A = 8'h12;
  localparam logic [7:0] REG_IN_B = 8'h13;
  localparam logic [7:0] REG_IN_C = 8'h14;
  localparam logic [7:0] REG_MASK_AB = 8'h15;
  localparam logic [7:0] REG_MASK_BC = 8'h16;
  localparam logic [7:0] REG_PMR0 = 8'h20;
  localparam logic [7:0] REG_PMR2 = 8'h22;
  localparam logic [7:0] REG_CTRL = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h25;
  localparam logic [7:0] REG_PROG_LO = 8'h30;
  localparam logic [7:0] REG_PROG_HI = 8'h31;
  localparam logic [7:0] REG_PROG_DATA = 8'h32;

  // register fields and reset values
  localparam int PMR0_FAST = 3;
  localparam int GATE_ALE = 0;
  localparam int GATE_RD = 1;
  localparam int GATE_WR = 2;
  localparam int GATE_PROGRAM_FETCH_STROBE = 3;
  localparam int GATE_PDN = 4;
  localparam int CTRL_EDGE_LOAD = 0;
  localparam logic [7:0] PMR0_RST = 8'h00;
  localparam logic [7:0] PMR2_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // standby timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STBY_TIME_NS = 70;
  localparam int STBY_CYC = (STBY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // decode select outputs
  typedef struct packed {
    logic [3:0] primary_sector_selects;
    logic [1:0] secondary_sector_selects;
    logic sram_select;
    logic control_register_space;
    logic [1:0] peripheral_selects;
  } dml_dec_t;

  // whole state of the block
  typedef struct packed {
    logic [CFG_BYTES-1:0][7:0] cfg;  // logic image
    logic [15:0] prog_addr;
    logic [7:0] pmr0;
    logic [7:0] pmr2;
    logic [7:0] mask_ab;
    logic [7:0] mask_bc;
    logic [7:0] ctrl;
    logic [15:0] cell_ff;
    logic [15:0] cell_out;
    logic [15:0] clk_prev;
    logic [21:0] in_s1;
    logic [21:0] in_s2;
    logic clk_ext_prev;
    logic pend_ab;
    logic pend_bc;
    logic [7:0] pend_data;
    logic [N_IN-1:0] in_prev;
    logic [4:0] idle_cnt;
    logic standby;
    logic [7:0] rdata;
    dml_dec_t dec;
    logic [1:0] ecs;
    logic [7:0] pa;
    logic [7:0] pa_en;
    logic [7:0] pb;
    logic [7:0] pb_en;
    logic [7:0] pc;
    logic [7:0] pc_en;
  } dml_state_t;

endpackage

// ===== bench/dml_cpu_model.sv
// processor core bus model driving the array's address and strobe inputs
`timescale 1ns/1ps
module dml_cpu_model (
  // clock
  input wire logic clk_i,
  // request from the bench
  input wire logic [15:0] req_addr_i,
  input wire logic [4:0] req_strb_i,
  // core lines: strobe bits 0 ale, 1 rd, 2 wr, 3 fetch, 4 power-down
  output logic [15:0] cpu_addr_o,
  output logic [4:0] cpu_strb_o
);
  // core moves its lines just after an edge and holds them for a whole cycle
  always_ff @(posedge clk_i) begin
    cpu_addr_o <= req_addr_i;
    cpu_strb_o <= req_strb_i;
  end
endmodule

// ===== bench/dml_top_tb_top.sv
// self-checking bench of the decode and macrocell logic block
`timescale 1ns/1ps
module dml_top_tb_top;
  ////////////////////////////////////////////////////////////////////////
  // stimulus and observed nets
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] req_addr = 16'h0000;
  logic [4:0] req_strb = 5'h00;
  logic [15:0] cpu_addr;
  logic [4:0] strb;
  logic [7:0] pins = 8'h00;  // port pins, toggled to wake the arrays
  logic [7:0] pa, pa_en, pb, pb_en, pc, pc_en;
  logic ext_clk = 1'b0;  // external cell clock pin
  logic [1:0] ecs;
  logic [15:0] dec_view;  // chip selects, sram and control space selects side by side
  dml_pkg::dml_dec_t dec;
  logic stby;
  int fail_count = 0;
  int total_checks = 0;

  // 200 MHz clock
  always #2.5 ref_clk_i = ~ref_clk_i;

  assign dec_view = {12'h000, ecs, dec.sram_select, dec.control_register_space};

  ////////////////////////////////////////////////////////////////////////
  // core side model and device
  dml_cpu_model i_cpu (.clk_i(ref_clk_i), .req_addr_i(req_addr), .req_strb_i(req_strb),
    .cpu_addr_o(cpu_addr), .cpu_strb_o(strb));

  dml_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .cpu_addr_i(cpu_addr), .program_fetch_strobe_i(strb[3]), .data_read_strobe_i(strb[1]),
    .data_write_strobe_i(strb[2]), .addr_latch_strobe_i(strb[0]), .cpu_reset_i(1'b0),
    .power_down_input_i(strb[4]), .page_bits_i(pins), .ready_busy_i(1'b0),
    .port_a_pins_i(pins), .port_b_pins_i(pins), .port_c_pins_i(pins[3:0]),
    .external_cell_clock_i(ext_clk), .port_d2_i(1'b0), .dec_sel_o(dec),
    .external_chip_selects_o(ecs), .port_a_o(pa), .port_a_en_o(pa_en), .port_b_o(pb),
    .port_b_en_o(pb_en), .port_c_o(pc), .port_c_en_o(pc_en), .standby_o(stby));

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, lowered at the edge that takes it
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    check({8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic cpu(input logic [15:0] a, input logic [4:0] s);
    @(posedge ref_clk_i);
    req_addr <= a;
    req_strb <= s;
  endtask

  // pointer is set low byte first, data writes then step it
  task automatic prog_at(input logic [15:0] p);
    wr_reg(dml_pkg::REG_PROG_LO, p[7:0]);
    wr_reg(dml_pkg::REG_PROG_HI, p[15:8]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd_chk(dml_pkg::REG_MASK_AB, dml_pkg::MASK_RST);
    rd_chk(dml_pkg::REG_MASK_BC, dml_pkg::MASK_RST);
    rd_chk(dml_pkg::REG_PMR0, dml_pkg::PMR0_RST);
    rd_chk(dml_pkg::REG_PMR2, dml_pkg::PMR2_RST);
    rd_chk(8'h7F, 8'h00);
  endtask

  // all sixteen cells registered, bc cells on their alternate port, then loaded
  task automatic t_load();
    prog_at(16'(dml_pkg::CELL_CFG_BASE));
    for (int i = 0; i < dml_pkg::N_CELLS; i++) begin
      wr_reg(dml_pkg::REG_PROG_DATA, (i < 8) ? 8'h02 : 8'h22);
    end
    wr_reg(dml_pkg::REG_CELLS_AB, 8'h55);
    rd_chk(dml_pkg::REG_CELLS_AB, 8'h55);
    wr_reg(dml_pkg::REG_CELLS_BC, 8'hA3);
    rd_chk(dml_pkg::REG_CELLS_BC, 8'hA3);
    settle(2);
    check({8'h00, pa}, 16'h0055);
    check({8'h00, pa_en}, 16'h00FF);
    check({8'h00, pc_en & 8'h63}, 16'h0000);
    check({pb_en, pc_en}, 16'h639C);
    check({pb, pc}, 16'h2380);
  endtask

  // masked low nibble keeps its old value
  task automatic t_mask();
    wr_reg(dml_pkg::REG_MASK_AB, 8'h0F);
    wr_reg(dml_pkg::REG_CELLS_AB, 8'hFF);
    rd_chk(dml_pkg::REG_CELLS_AB, 8'hF5);
    wr_reg(dml_pkg::REG_MASK_AB, 8'h00);
  endtask

  // edge mode: nothing moves at the write edge, the load lands one edge later
  task automatic t_edge();
    wr_reg(dml_pkg::REG_CTRL, 8'h01);
    wr_reg(dml_pkg::REG_CELLS_AB, 8'h3C);
    settle(0);
    check({8'h00, pa}, 16'h00F5);
    wr_reg(dml_pkg::REG_CELLS_BC, 8'h08);
    settle(2);
    rd_chk(dml_pkg::REG_CELLS_AB, 8'h3C);
    rd_chk(dml_pkg::REG_CELLS_BC, 8'h08);
    wr_reg(dml_pkg::REG_CTRL, 8'h00);
  endtask

  // control space, sram and chip select 0 terms = address bit 15 and read strobe
  task automatic t_decode();
    logic [7:0] b;
    int t;
    for (int j = 0; j < 3; j++) begin
      t = (j == 0) ? dml_pkg::PT_CREG : (j == 1) ? dml_pkg::PT_SRAM : dml_pkg::PT_ECS;
      prog_at(16'(t * dml_pkg::TERM_BYTES));
      for (int i = 0; i < dml_pkg::TERM_BYTES; i++) begin
        b = (i == 1) ? 8'h80 : (i == 2) ? 8'h02 : 8'h00;
        if (i == dml_pkg::TERM_EN_BIT / 8) b = 8'(1 << (dml_pkg::TERM_EN_BIT % 8));
        wr_reg(dml_pkg::REG_PROG_DATA, b);
      end
    end
    cpu(16'h8000, 5'h02);
    settle(4);
    check(dec_view, 16'h0007);
    cpu(16'h0000, 5'h02);
    settle(4);
    check(dec_view, 16'h0000);
    // read and write strobes both up, both gated away
    cpu(16'h8000, 5'h06);
    wr_reg(dml_pkg::REG_PMR2, 8'h06);
    settle(4);
    check(dec_view, 16'h0000);
    wr_reg(dml_pkg::REG_PMR2, 8'h00);
    cpu(16'h0000, 5'h00);
  endtask

  // inverted empty sum makes ab cell 0 toggle on each rising external clock edge
  task automatic t_extclk();
    prog_at(16'(dml_pkg::CELL_CFG_BASE));
    wr_reg(dml_pkg::REG_PROG_DATA, 8'h17);
    settle(4);
    check({15'h0000, pa[0]}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk_i);
      ext_clk <= ~ext_clk;
      settle(5);
      check({15'h0000, pa[0]}, (i == 2) ? 16'h0000 : 16'h0001);
    end
  endtask

  // quiet inputs for longer than the idle span, then a pin change
  task automatic t_standby();
    settle(dml_pkg::STBY_CYC + 6);
    check({15'h0000, stby}, 16'h0001);
    @(posedge ref_clk_i);
    pins <= 8'hA5;
    settle(5);
    check({15'h0000, stby}, 16'h0000);
    rd_chk(dml_pkg::REG_IN_A, 8'hA5);
    rd_chk(dml_pkg::REG_IN_C, 8'h14);
    wr_reg(dml_pkg::REG_PMR0, 8'h08);
    settle(dml_pkg::STBY_CYC + 6);
    check({15'h0000, stby}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // verdict, reached from the sequence or the watchdog
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_load();
    t_mask();
    t_edge();
    t_decode();
    t_extclk();
    t_standby();
    tally_and_finish();
  end

  // watchdog, far beyond the roughly 300 cycles the tests need
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule
